// file: motor_cmd_defs.svh
// Purpose: constants for the motor command front end
// Assumes: 100 MHz core clock
// Notes: offsets, field positions, reset values and timing counts
`ifndef MOTOR_CMD_DEFS_SVH
`define MOTOR_CMD_DEFS_SVH
`define FRAME_BYTES 4'h8
`define RESP_HEADER 8'h7A
`define FACTORY_ADDR 8'hFF
`define ERR_STATE 32'h00000006
`define ERR_UNKNOWN 32'h00000007
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_CMD 8'h08
`define OFS_RESP 8'h0C
`define OFS_ADDR 8'h10
`define CTRL_SUPPLY 0
`define CTRL_TRIG1 2:1
`define CTRL_TRIG2 4:3
`define CTRL_CLR1 5
`define CTRL_CLR2 6
`define TRIG_FALL 2'h0
`define TRIG_RISE 2'h1
`define GAP_TIMEOUT_US 2000
`define CLK_MHZ 100
`define GAP_CYCLES (`GAP_TIMEOUT_US * `CLK_MHZ)
`endif

// file: motor_cmd_pkg.sv
// Purpose: types for the motor command front end
// Assumes: nothing
// Notes: constants live in motor_cmd_defs.svh
package motor_cmd_pkg;
  typedef enum logic [1:0] {
    LINK_RX = 2'b00,
    LINK_EXEC = 2'b01,
    LINK_TX = 2'b11
  } link_state_type;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] opcode;
    logic [31:0] data;
  } cmd_type;
  typedef struct packed {
    logic phaseA;
    logic phaseB;
    logic index;
  } encoder_type;
endpackage

// file: motor_cmd_frame.sv
// Purpose: 8-byte command frame receiver, responder and limit/encoder inputs
// Assumes: byte link uart outside; inputs synchronous to core_clk
// Notes: instruction execution happens outside, behind the AXI4-Lite registers
`include "motor_cmd_defs.svh"
`timescale 1ns/10ps
`default_nettype none

// How it works
// [RULE1] frames in and out are exactly eight bytes, back to back
// [RULE2] receiving and sending never overlap; one link direction at a time
// [RULE3] transmit only as answer to a host frame, never spontaneously
// [RULE4] matching address and good check byte always get an answer
// [RULE5] answer sent only after execution logic returns its result
// [RULE6] a frame ends only after eight bytes; short frames wait out timeout
// [RULE7] wrong address or check byte: frame dropped, nothing sent
// [RULE8] host waits its own timeout when no answer comes
// [RULE9] device address resets to ff; first setup with single controller
// [RULE10] each limit input has its own trigger mode, changeable anytime
// [RULE11] both limit inputs default to falling edge trigger
// [RULE12] limit signal low when isolated loop conducts, high when open
// [RULE13] user picks rising for light-blocked optics, falling for switches
// [RULE14] second limit or analog input, chosen by build parameter only
// [RULE15] analog mode: 3.3V full scale to max speed, below threshold zero; the code passes the raw sample on with no scaling or threshold
// [RULE16] switched sensor supply follows a dedicated output bit
// [RULE17] encoder phase A, phase B and index on three inputs
// [RULE18] last byte is carry-dropped sum of the first seven
// [RULE19] answer starts with 7a then the own device address
// [RULE20] data is signed 32 bits, least significant byte first
// [RULE21] failed instruction replies error 6 for state, 7 for unknown
// [RULE22] too long a gap between bytes discards a partial frame
module motor_cmd_frame #(
  parameter int GAP_CYCLES = `GAP_CYCLES,
  parameter bit ANALOG_BUILD = 1'b0,
  parameter int ADC_BITS = 12
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // byte link
  input wire logic [7:0] rxByte,
  input wire logic rxValid,
  output logic [7:0] txByte,
  output logic txValid,
  input wire logic txReady,
  // pins
  input wire logic limit_input_one,
  input wire logic limit_input_two,
  input wire logic [ADC_BITS-1:0] analog_speed_input,
  input wire motor_cmd_pkg::encoder_type encoder,
  output logic sensorSupplyOn,
  output logic [ADC_BITS-1:0] analogSpeed,
  output logic limitOneEvent,
  output logic limitTwoEvent,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  motor_cmd_pkg::link_state_type state_reg;
  logic [63:0] frame_reg;
  logic [3:0] count_reg;
  logic [31:0] gap_reg;
  logic [7:0] sum_reg;
  logic [7:0] devAddr_reg;
  logic [6:0] ctrl_reg;
  motor_cmd_pkg::cmd_type cmd_reg;
  logic cmdPending_reg;
  logic [31:0] resp_reg;
  logic [63:0] txFrame_reg;
  logic [1:0] lim1_reg;
  logic [1:0] lim2_reg;
  logic flag1_reg;
  logic flag2_reg;
  logic [2:0] enc_reg;
  logic awHeld_reg;
  logic wHeld_reg;
  logic [7:0] awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;
  logic respWrite;
  logic ctrlWrite;
  logic [7:0] nextSum;
  logic frameOk;
  logic [7:0] respSum;
  logic hit1;
  logic hit2;

  // carry-dropped running sum; byte 8 compared against first seven
  assign nextSum = sum_reg + rxByte; // RULE18
  // byte one is the address; byte zero is the host's header and is not checked
  assign frameOk = (rxByte == sum_reg) && (frame_reg[47:40] == devAddr_reg); // RULE7
  assign respSum = 8'(`RESP_HEADER + devAddr_reg + resp_reg[7:0] + resp_reg[15:8]
    + resp_reg[23:16] + resp_reg[31:24]); // RULE18

  // receive, execute handshake, transmit; one direction at a time
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg <= motor_cmd_pkg::LINK_RX;
      frame_reg <= 64'h0;
      count_reg <= 4'h0;
      gap_reg <= 32'h0;
      sum_reg <= 8'h00;
      cmd_reg <= '0;
      cmdPending_reg <= 1'b0;
      txFrame_reg <= 64'h0;
    end else begin
      case (state_reg)
        motor_cmd_pkg::LINK_RX: begin // RULE2
          if (rxValid) begin
            gap_reg <= 32'h0;
            frame_reg <= {frame_reg[55:0], rxByte};
            if (count_reg == `FRAME_BYTES - 4'h1) begin // RULE1 RULE6
              count_reg <= 4'h0;
              sum_reg <= 8'h00;
              if (frameOk) begin // RULE4
                cmd_reg.addr <= frame_reg[47:40];
                cmd_reg.opcode <= frame_reg[39:32];
                cmd_reg.data <= {frame_reg[7:0], frame_reg[15:8],
                  frame_reg[23:16], frame_reg[31:24]}; // RULE20
                cmdPending_reg <= 1'b1;
                state_reg <= motor_cmd_pkg::LINK_EXEC;
              end
            end else begin
              count_reg <= count_reg + 4'h1;
              sum_reg <= nextSum;
            end
          end else if (count_reg != 4'h0) begin
            if (gap_reg >= 32'(GAP_CYCLES - 1)) begin // RULE22
              count_reg <= 4'h0;
              sum_reg <= 8'h00;
              gap_reg <= 32'h0;
            end else begin
              gap_reg <= gap_reg + 32'h1;
            end
          end
        end
        motor_cmd_pkg::LINK_EXEC: begin // RULE5
          if (respWrite) begin
            cmdPending_reg <= 1'b0;
            state_reg <= motor_cmd_pkg::LINK_TX;
          end
        end
        motor_cmd_pkg::LINK_TX: begin // RULE3
          if (txValid && txReady) begin
            txFrame_reg <= {txFrame_reg[55:0], 8'h00};
            if (count_reg == `FRAME_BYTES - 4'h1) begin
              count_reg <= 4'h0;
              state_reg <= motor_cmd_pkg::LINK_RX;
            end else begin
              count_reg <= count_reg + 4'h1;
            end
          end
        end
        default: state_reg <= motor_cmd_pkg::LINK_RX;
      endcase
      if (state_reg == motor_cmd_pkg::LINK_EXEC && respWrite) begin
        txFrame_reg <= {`RESP_HEADER, devAddr_reg, wData_reg[7:0], wData_reg[15:8],
          wData_reg[23:16], wData_reg[31:24], 8'h00, 8'h00}; // RULE19 RULE20
      end
    end
  end

  // tx byte: check byte substituted in slot eight
  assign txValid = (state_reg == motor_cmd_pkg::LINK_TX); // RULE1
  assign txByte = (count_reg == `FRAME_BYTES - 4'h1) ? respSum : txFrame_reg[63:56];

  // response data latched with the frame
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      resp_reg <= 32'h0;
    end else if (state_reg == motor_cmd_pkg::LINK_EXEC && respWrite) begin
      resp_reg <= wData_reg; // RULE21
    end
  end

  // limit inputs: loop conducting gives low; edge chosen per input
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lim1_reg <= 2'b11;
      lim2_reg <= 2'b11;
      enc_reg <= 3'b000;
    end else begin
      lim1_reg <= {lim1_reg[0], limit_input_one}; // RULE12
      lim2_reg <= {lim2_reg[0], ANALOG_BUILD ? 1'b1 : limit_input_two}; // RULE14
      enc_reg <= {encoder.phaseA, encoder.phaseB, encoder.index}; // RULE17
    end
  end

  // trigger mode: 0 falling, 1 rising, 2/3 both edges
  function automatic logic edgeHit(input logic [1:0] s, input logic [1:0] m);
    case (m)
      `TRIG_FALL: edgeHit = s[1] & ~s[0]; // RULE11
      `TRIG_RISE: edgeHit = ~s[1] & s[0]; // RULE13
      default: edgeHit = s[1] ^ s[0];
    endcase
  endfunction
  assign hit1 = edgeHit(lim1_reg, ctrl_reg[`CTRL_TRIG1]); // RULE10
  assign hit2 = edgeHit(lim2_reg, ctrl_reg[`CTRL_TRIG2]); // RULE10
  assign limitOneEvent = flag1_reg;
  assign limitTwoEvent = flag2_reg;

  // sticky limit flags; a new edge wins over the clear
  // clear taken from the write word itself, since the clear bits never stay in ctrl_reg
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      flag1_reg <= 1'b0;
      flag2_reg <= 1'b0;
    end else begin
      flag1_reg <= hit1 | (flag1_reg & ~(ctrlWrite & wData_reg[`CTRL_CLR1]));
      flag2_reg <= hit2 | (flag2_reg & ~(ctrlWrite & wData_reg[`CTRL_CLR2]));
    end
  end

  // analog sample passed on only in the analog build; scaling is offline
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      analogSpeed <= '0;
    end else begin
      analogSpeed <= ANALOG_BUILD ? analog_speed_input : '0; // RULE15
    end
  end
  assign sensorSupplyOn = ctrl_reg[`CTRL_SUPPLY]; // RULE16

  // axi write: address and data caught in either order
  assign s_axi_awready = ~awHeld_reg & ~s_axi_bvalid;
  assign s_axi_wready = ~wHeld_reg & ~s_axi_bvalid;
  assign respWrite = awHeld_reg && wHeld_reg && !s_axi_bvalid && awAddr_reg == `OFS_RESP;
  assign ctrlWrite = awHeld_reg && wHeld_reg && !s_axi_bvalid && awAddr_reg == `OFS_CTRL
    && wStrb_reg[0];
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      awAddr_reg <= 8'h00;
      wData_reg <= 32'h0;
      wStrb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      ctrl_reg <= 7'h00; // RULE11
      devAddr_reg <= `FACTORY_ADDR; // RULE9
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_reg <= 1'b1;
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end
      if (awHeld_reg && wHeld_reg && !s_axi_bvalid) begin
        awHeld_reg <= 1'b0;
        wHeld_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'b00;
        case (awAddr_reg)
          `OFS_CTRL: if (wStrb_reg[0]) ctrl_reg <= wData_reg[6:0];
          `OFS_ADDR: if (wStrb_reg[0]) devAddr_reg <= wData_reg[7:0];
          `OFS_RESP: ;
          default: s_axi_bresp <= 2'b10;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (awHeld_reg && wHeld_reg && !s_axi_bvalid && awAddr_reg == `OFS_CTRL) begin
        ctrl_reg[6:5] <= 2'b00; // clear bits are self-clearing strobes
      end
    end
  end

  // axi read
  assign s_axi_arready = ~s_axi_rvalid;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'b00;
      case (s_axi_araddr)
        `OFS_CTRL: s_axi_rdata <= {25'h0, ctrl_reg};
        `OFS_STATUS: s_axi_rdata <= {24'h0, enc_reg, flag2_reg, flag1_reg,
          cmdPending_reg, state_reg};
        `OFS_CMD: s_axi_rdata <= cmd_reg.data;
        `OFS_RESP: s_axi_rdata <= {16'h0, cmd_reg.opcode, cmd_reg.addr};
        `OFS_ADDR: s_axi_rdata <= {24'h0, devAddr_reg};
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= 2'b10;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: motor_cmd_frame_checker.sv
// Purpose: port checks on the motor command front end
// Assumes: one clock, reset high
// Notes: reply beats are counted here to find header and check byte
`timescale 1ns/10ps
`default_nettype none
module motor_cmd_frame_checker (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // byte link
  input wire logic [7:0] txByte,
  input wire logic txValid,
  input wire logic txReady,
  // register writes
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic sensorSupplyOn
);
  logic [2:0] beat;
  logic [7:0] sum;
  logic armed;
  logic want;
  wire logic tb = txValid && txReady;
  wire logic wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  // beat count and running sum of the outgoing frame
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      beat <= 3'h0;
      sum <= 8'h00;
    end else if (tb) begin
      beat <= beat + 3'h1;
      sum <= (beat == 3'h7) ? 8'h00 : sum + txByte;
    end
  end
  // a reply may only start once software has written the reply word
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      armed <= 1'b0;
      want <= 1'b0;
    end else begin
      if (wr && s_axi_awaddr == 8'h0C) armed <= 1'b1;
      else if (tb && beat == 3'h7) armed <= 1'b0;
      if (wr && s_axi_awaddr == 8'h00) want <= s_axi_wdata[0];
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  AST_HEADER: assert property (tb && beat == 3'h0 |-> txByte == 8'h7A)
    else $error("bad reply header");
  AST_CHECK_BYTE: assert property (tb && beat == 3'h7 |-> txByte == sum)
    else $error("bad reply check byte");
  AST_NO_GAP: assert property (tb && beat != 3'h7 |=> txValid)
    else $error("gap inside reply");
  AST_FRAME_END: assert property (tb && beat == 3'h7 |=> !txValid)
    else $error("reply longer than eight bytes");
  AST_HOLD: assert property (txValid && !txReady |=> txValid && $stable(txByte))
    else $error("reply byte dropped");
  AST_ANSWER_ONLY: assert property ($rose(txValid) |-> armed)
    else $error("reply without executed command");
  AST_SUPPLY: assert property (wr && s_axi_awaddr == 8'h00 |-> ##[1:3] sensorSupplyOn == want)
    else $error("supply output wrong");
  AST_WRITE_RESP: assert property (wr |-> ##[1:2] s_axi_bvalid)
    else $error("no write response");
endmodule
bind motor_cmd_frame motor_cmd_frame_checker chk (.*);
`default_nettype wire

// file: host_model.sv
// Purpose: host side of the byte link
// Assumes: one byte per cycle while valid
// Notes: slow mode drops txReady on every other cycle
`timescale 1ns/10ps
`default_nettype none
module host_model #(
  parameter logic [7:0] HDR = 8'h3E
) (
  // clock and mode
  input wire logic core_clk,
  input wire logic rst,
  input wire logic slow,
  // byte link
  input wire logic [7:0] txByte,
  input wire logic txValid,
  output logic txReady,
  output logic [7:0] rxByte,
  output logic rxValid
);
  logic [7:0] got [$];
  logic stall;
  initial {rxByte, rxValid} = 9'h000;
  // back-pressure on alternate cycles
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) stall <= 1'b0;
    else stall <= slow && !stall;
  end
  assign txReady = !stall;
  // keep reply bytes for the bench
  always @(posedge core_clk) begin
    if (txValid && txReady) got.push_back(txByte);
  end
  // header, address, opcode, data low byte first, carry-dropped sum
  task automatic send(input logic [7:0] adr, input logic [7:0] op, input logic [31:0] d,
    input logic [7:0] bad, input int n);
    logic [7:0] f [8];
    f = '{HDR, adr, op, d[7:0], d[15:8], d[23:16], d[31:24], bad};
    for (int i = 0; i < 7; i++) f[7] = f[7] + f[i];
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      rxByte <= f[i];
      rxValid <= 1'b1;
    end
    @(posedge core_clk);
    rxByte <= ~f[n - 1];
    rxValid <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: motor_cmd_frame_and_limit_inputs_test.sv
// Purpose: register and link scenarios for the motor command front end
// Assumes: host_model on the link, short gap timeout
// Notes: expectations come from frame layout and register map
`timescale 1ns/10ps
`default_nettype none
module motor_cmd_frame_and_limit_inputs_test;
  logic core_clk, rst, rxValid, txValid, txReady, slow, sensorSupplyOn;
  logic limit_input_one, limit_input_two, limitOneEvent, limitTwoEvent;
  logic [7:0] rxByte, txByte, s_axi_awaddr, s_axi_araddr;
  logic [11:0] analogSpeed;
  logic [11:0] analog_speed_input;
  motor_cmd_pkg::encoder_type encoder;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int comparisons, miscompares;
  motor_cmd_frame #(.GAP_CYCLES(20)) uut (.*, .s_axi_wstrb(4'hF));
  host_model host (.*);
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    {aw, w} = 2'b11;
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    while (aw || w) begin
      @(posedge core_clk);
      if (s_axi_awready) aw = 1'b0;
      if (s_axi_wready) w = 1'b0;
      {s_axi_awvalid, s_axi_wvalid} <= {aw, w};
    end
    do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
    // bready stays high; lowering it would meet the next call's raise in one step
    check(32'(s_axi_bresp), 32'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, e, input logic [1:0] er);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do @(posedge core_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
    // rready stays high for the same reason as bready
    check(s_axi_rdata & m, e);
    check(32'(s_axi_rresp), 32'(er));
  endtask
  // software runs the command, then the whole reply must come back
  task automatic reply(input logic [31:0] cmd, input logic [15:0] hdr, input logic [31:0] d);
    logic [7:0] e [8];
    e = '{8'h7A, 8'hFF, d[7:0], d[15:8], d[23:16], d[31:24], 8'h00, 8'h00};
    for (int i = 0; i < 7; i++) e[7] = e[7] + e[i];
    repeat (4) @(posedge core_clk);
    rd(8'h04, 32'h3, 32'h1, 2'h0);
    rd(8'h08, 32'hFFFFFFFF, cmd, 2'h0);
    rd(8'h0C, 32'hFFFF, {16'h0, hdr}, 2'h0);
    wr(8'h0C, d);
    for (int t = 0; t < 200 && host.got.size() < 8; t++) @(posedge core_clk);
    for (int i = 0; i < 8; i++) check(32'(host.got[i]), 32'(e[i]));
    host.got.delete();
  endtask
  // a dropped frame leaves the link silent and the receiver idle
  task automatic idle();
    repeat (30) @(posedge core_clk);
    check(32'(host.got.size()), 32'h0);
    rd(8'h04, 32'h3, 32'h0, 2'h0);
  endtask
  task automatic conclude();
    if (miscompares == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    {rst, limit_input_one, limit_input_two} = 3'b111;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, slow} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, encoder} = '0;
    analog_speed_input = 12'hABC;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    rd(8'h10, 32'hFF, 32'hFF, 2'h0);
    rd(8'h00, 32'h1F, 32'h0, 2'h0);
    rd(8'h20, 32'h0, 32'h0, 2'h2);
    check(32'(analogSpeed), 32'h0);
    limit_input_one <= 1'b0;
    repeat (4) @(posedge core_clk);
    check(32'(limitOneEvent), 32'h1);
    wr(8'h00, 32'h6B);
    check(32'({limitOneEvent, limitTwoEvent, sensorSupplyOn}), 32'h1);
    limit_input_two <= 1'b0;
    repeat (4) @(posedge core_clk);
    check(32'(limitTwoEvent), 32'h0);
    {limit_input_one, limit_input_two} <= 2'b11;
    repeat (4) @(posedge core_clk);
    check(32'({limitOneEvent, limitTwoEvent}), 32'h3);
    wr(8'h00, 32'h64);
    check(32'({limitOneEvent, limitTwoEvent, sensorSupplyOn}), 32'h0);
    limit_input_one <= 1'b0;
    repeat (4) @(posedge core_clk);
    check(32'({limitOneEvent, limitTwoEvent}), 32'h2);
    encoder <= 3'b101;
    @(posedge core_clk); // status samples the pins one cycle late
    rd(8'h04, 32'hE0, 32'hA0, 2'h0);
    slow <= 1'b1;
    host.send(8'hFF, 8'h77, 32'h12345678, 8'h00, 8);
    reply(32'h12345678, 16'h77FF, 32'h6);
    host.send(8'hFF, 8'h77, 32'h1, 8'h01, 8);
    idle();
    host.send(8'h05, 8'h77, 32'h1, 8'h00, 8);
    idle();
    host.send(8'hFF, 8'h00, 32'h0, 8'h00, 3);
    idle();
    slow <= 1'b0;
    host.send(8'hFF, 8'h00, 32'hFFFFFFFA, 8'h00, 8);
    reply(32'hFFFFFFFA, 16'h00FF, 32'h7);
    conclude();
  end
  // cut a hang short
  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    conclude();
  end
endmodule
`default_nettype wire
